// [hdl/qcl_regs.svh]
`ifndef QCL_REGS_SVH
`define QCL_REGS_SVH

// bus geometry: byte address = {channel, register, 2'h0}
`define QCL_ADDR_W        7
`define QCL_CH_W          3
`define QCL_CH_LSB        4
`define QCL_CH_MSB        6
`define QCL_REG_LSB       2
`define QCL_REG_MSB       3

// register selector within one channel block
`define QCL_REG_CFG       2'h0
`define QCL_REG_POS       2'h1
`define QCL_REG_CAP       2'h2
`define QCL_REG_STAT      2'h3

// configuration fields
`define QCL_CFG_MODE_LSB  0
`define QCL_CFG_MODE_MSB  1
`define QCL_CFG_POL_BIT   2
`define QCL_CFG_CLR_BIT   3
`define QCL_CFG_POL_RST   1'h1

// status fields written as one-to-clear
`define QCL_STAT_ERR_BIT  1

// counter and capture width
`define QCL_CNT_W         24
`define QCL_CNT_RST       24'h000000
`define QCL_CNT_ONE       24'h000001

// bus responses
`define QCL_RESP_OKAY     2'h0
`define QCL_RESP_SLVERR   2'h2

`endif

// [hdl/qcl_pkg.sv]
package qcl_pkg;

    // capture trigger selection
    typedef enum logic [1:0] {
        QCL_MODE_OFF   = 2'b00,
        QCL_MODE_INDEX = 2'b01,
        QCL_MODE_FAST  = 2'b10,
        QCL_MODE_ARMED = 2'b11
    } qcl_mode_t;

    // armed-index sequencing
    typedef enum logic {
        QCL_ST_IDLE  = 1'b0,
        QCL_ST_ARMED = 1'b1
    } qcl_cap_state_t;

endpackage

// [hdl/qcl_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module qcl_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // asynchronous pins and filtered result
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] out_r;
    logic [WIDTH-1:0] out_nxt;

    // a bit moves only once stages two and three agree
    assign out_nxt = (s2_r & s3_r) | (out_r & (s2_r | s3_r));
    assign dout    = out_r;

    // three-stage chain, first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            out_r <= '0;
        end else begin
            s1_r  <= din;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            out_r <= out_nxt;
        end
    end

endmodule // qcl_sync

`default_nettype wire

// [hdl/qcl_capture.sv]
`timescale 1ns/1ps
`default_nettype none

module qcl_capture (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // synchronised levels
    input  wire logic              index_lvl,
    input  wire logic              fast_lvl,
    // configuration
    input  wire qcl_pkg::qcl_mode_t mode,
    input  wire logic              fast_rising,
    // results
    output logic                   capture,
    output logic                   armed
);

    logic                    idx_prev_r;
    logic                    fast_prev_r;
    qcl_pkg::qcl_cap_state_t state_r;
    qcl_pkg::qcl_cap_state_t state_nxt;
    logic                    idx_rise;
    logic                    fast_edge;
    logic                    in_armed;

    // edge detection on filtered levels
    assign idx_rise  = index_lvl & ~idx_prev_r;
    assign fast_edge = fast_rising ? (fast_lvl & ~fast_prev_r)
                                   : (~fast_lvl & fast_prev_r);
    assign in_armed  = (state_r == qcl_pkg::QCL_ST_ARMED);
    assign armed     = in_armed;

    // trigger selection, no software in the path
    always_comb begin
        case (mode)
            qcl_pkg::QCL_MODE_INDEX: capture = idx_rise;
            qcl_pkg::QCL_MODE_FAST:  capture = fast_edge;
            qcl_pkg::QCL_MODE_ARMED: capture = in_armed & idx_rise;
            default:                 capture = 1'b0;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        if (mode != qcl_pkg::QCL_MODE_ARMED) begin
            state_nxt = qcl_pkg::QCL_ST_IDLE;
        end else begin
            case (state_r)
                qcl_pkg::QCL_ST_IDLE: begin
                    if (fast_edge) begin
                        state_nxt = qcl_pkg::QCL_ST_ARMED;
                    end
                end
                qcl_pkg::QCL_ST_ARMED: begin
                    if (idx_rise) begin
                        state_nxt = qcl_pkg::QCL_ST_IDLE;
                    end
                end
                default: state_nxt = qcl_pkg::QCL_ST_IDLE;
            endcase
        end
    end

    // history and state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idx_prev_r  <= 1'h0;
            fast_prev_r <= 1'h0;
            state_r     <= qcl_pkg::QCL_ST_IDLE;
        end else begin
            idx_prev_r  <= index_lvl;
            fast_prev_r <= fast_lvl;
            state_r     <= state_nxt;
        end
    end

endmodule // qcl_capture

`default_nettype wire

// [hdl/qcl_top.sv]
// Notes on behaviour
// - phase order gives counting direction
// - one 24-bit position counter per channel
// - step on every A and B edge; an A and a B edge in the same cycle set the error flag and do not step
// - keep up with one million counts/second
// - 24-bit capture snapshot per channel
// - index pulse captures the count
// - fast input edge of chosen polarity captures
// - fast edge arms, next index captures
// - five channels, each with fast input
// - capture in hardware, no software delay
`timescale 1ns/1ps
`default_nettype none

`include "qcl_regs.svh"

module qcl_top #(
    parameter int NCH = 5
) (
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // axi4-lite write address
    input  wire logic [`QCL_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]             s_axi_awprot,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // axi4-lite read address
    input  wire logic [`QCL_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]             s_axi_arprot,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // encoder and fast inputs, one bit per channel
    input  wire logic [NCH-1:0]         enc_a,
    input  wire logic [NCH-1:0]         enc_b,
    input  wire logic [NCH-1:0]         enc_index,
    input  wire logic [NCH-1:0]         fast_in
);

    // write channel holding registers
    logic                   aw_held_r;
    logic [`QCL_ADDR_W-1:0] aw_addr_r;
    logic                   w_held_r;
    logic [31:0]            w_data_r;
    logic [3:0]             w_strb_r;
    logic                   bvalid_r;
    logic [1:0]             bresp_r;
    // read channel registers
    logic                   rvalid_r;
    logic [31:0]            rdata_r;
    logic [1:0]             rresp_r;
    logic [31:0]            rdata_nxt;

    // decoded bus fields
    logic                   aw_hs;
    logic                   w_hs;
    logic                   ar_hs;
    logic                   wr_fire;
    logic [`QCL_CH_W-1:0]   wr_ch;
    logic [1:0]             wr_reg;
    logic                   wr_ok;
    logic [`QCL_CH_W-1:0]   rd_ch;
    logic [1:0]             rd_reg;
    logic                   rd_ok;
    logic                   wr_lane0;

    // per-channel read views
    logic [31:0]            cfg_w  [NCH];
    logic [31:0]            pos_w  [NCH];
    logic [31:0]            cap_w  [NCH];
    logic [31:0]            stat_w [NCH];

    // handshakes: one write and one read in flight
    assign s_axi_awready = ~aw_held_r & ~bvalid_r;
    assign s_axi_wready  = ~w_held_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;
    assign aw_hs         = s_axi_awvalid & s_axi_awready;
    assign w_hs          = s_axi_wvalid & s_axi_wready;
    assign ar_hs         = s_axi_arvalid & s_axi_arready;
    assign wr_fire       = aw_held_r & w_held_r & ~bvalid_r;

    // address decode
    assign wr_ch    = aw_addr_r[`QCL_CH_MSB:`QCL_CH_LSB];
    assign wr_reg   = aw_addr_r[`QCL_REG_MSB:`QCL_REG_LSB];
    assign wr_ok    = (wr_ch < NCH[`QCL_CH_W-1:0]);
    assign wr_lane0 = w_strb_r[0];
    assign rd_ch    = s_axi_araddr[`QCL_CH_MSB:`QCL_CH_LSB];
    assign rd_reg   = s_axi_araddr[`QCL_REG_MSB:`QCL_REG_LSB];
    assign rd_ok    = (rd_ch < NCH[`QCL_CH_W-1:0]);

    // outputs from registers
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

    // write address and data are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'h0;
            aw_addr_r <= '0;
            w_held_r  <= 1'h0;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_held_r <= 1'h1;
                aw_addr_r <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_r <= 1'h0;
            end
            if (w_hs) begin
                w_held_r <= 1'h1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_r <= 1'h0;
            end
        end
    end

    // write response, slverr outside the channel range
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'h0;
            bresp_r  <= `QCL_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'h1;
            bresp_r  <= wr_ok ? `QCL_RESP_OKAY : `QCL_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'h0;
        end
    end

    // read data selection, unmapped reads return zero
    always_comb begin
        rdata_nxt = 32'h00000000;
        for (int i = 0; i < NCH; i++) begin
            if (rd_ch == i[`QCL_CH_W-1:0]) begin
                case (rd_reg)
                    `QCL_REG_CFG:  rdata_nxt = cfg_w[i];
                    `QCL_REG_POS:  rdata_nxt = pos_w[i];
                    `QCL_REG_CAP:  rdata_nxt = cap_w[i];
                    `QCL_REG_STAT: rdata_nxt = stat_w[i];
                    default:       rdata_nxt = 32'h00000000;
                endcase
            end
        end
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'h0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= `QCL_RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_r <= 1'h1;
            rdata_r  <= rdata_nxt;
            rresp_r  <= rd_ok ? `QCL_RESP_OKAY : `QCL_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'h0;
        end
    end

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        logic [3:0]            syn;
        logic                  a_s;
        logic                  b_s;
        logic                  idx_s;
        logic                  fast_s;
        logic                  a_prev_r;
        logic                  b_prev_r;
        logic [`QCL_CNT_W-1:0] cnt_r;
        logic [`QCL_CNT_W-1:0] cnt_nxt;
        logic [`QCL_CNT_W-1:0] cap_r;
        logic                  done_r;
        logic                  err_r;
        logic                  dir_r;
        qcl_pkg::qcl_mode_t    mode_r;
        logic                  pol_r;
        logic                  da;
        logic                  db;
        logic                  step;
        logic                  up;
        logic                  clash;
        logic                  cap_hit;
        logic                  armed;
        logic                  cfg_wr;
        logic                  stat_wr;
        logic                  cnt_clr;
        logic                  cap_rd;
        logic                  err_clr;

        qcl_sync #(
            .WIDTH (4)
        ) u_sync (
            .aclk    (aclk),
            .aresetn (aresetn),
            .din     ({fast_in[g], enc_index[g], enc_b[g], enc_a[g]}),
            .dout    (syn)
        );

        assign a_s    = syn[0];
        assign b_s    = syn[1];
        assign idx_s  = syn[2];
        assign fast_s = syn[3];

        // register strobes for this channel
        assign cfg_wr  = wr_fire & wr_ok & (wr_ch == g[`QCL_CH_W-1:0])
                       & (wr_reg == `QCL_REG_CFG) & wr_lane0;
        assign stat_wr = wr_fire & wr_ok & (wr_ch == g[`QCL_CH_W-1:0])
                       & (wr_reg == `QCL_REG_STAT) & wr_lane0;
        assign cnt_clr = cfg_wr & w_data_r[`QCL_CFG_CLR_BIT];
        assign err_clr = stat_wr & w_data_r[`QCL_STAT_ERR_BIT];
        assign cap_rd  = ar_hs & rd_ok & (rd_ch == g[`QCL_CH_W-1:0])
                       & (rd_reg == `QCL_REG_CAP);

        assign da    = a_s ^ a_prev_r;
        assign db    = b_s ^ b_prev_r;
        assign step  = da ^ db;
        assign clash = da & db;
        assign up    = da ? (a_s != b_s) : (b_s == a_s);

        assign cnt_nxt = cnt_clr ? `QCL_CNT_RST
                       : !step   ? cnt_r
                       : up      ? cnt_r + `QCL_CNT_ONE
                       :           cnt_r - `QCL_CNT_ONE;

        // capture trigger logic
        qcl_capture u_cap (
            .aclk        (aclk),
            .aresetn     (aresetn),
            .index_lvl   (idx_s),
            .fast_lvl    (fast_s),
            .mode        (mode_r),
            .fast_rising (pol_r),
            .capture     (cap_hit),
            .armed       (armed)
        );

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                a_prev_r <= 1'h0;
                b_prev_r <= 1'h0;
                cnt_r    <= `QCL_CNT_RST;
                dir_r    <= 1'h0;
            end else begin
                a_prev_r <= a_s;
                b_prev_r <= b_s;
                cnt_r    <= cnt_nxt;
                if (step) begin
                    dir_r <= up;
                end
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cap_r  <= `QCL_CNT_RST;
                done_r <= 1'h0;
                err_r  <= 1'h0;
            end else begin
                if (cap_hit) begin
                    cap_r <= cnt_r;
                end
                done_r <= cap_hit | (done_r & ~cap_rd);
                err_r  <= clash | (err_r & ~err_clr);
            end
        end

        // configuration register
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                mode_r <= qcl_pkg::QCL_MODE_OFF;
                pol_r  <= `QCL_CFG_POL_RST;
            end else if (cfg_wr) begin
                mode_r <= qcl_pkg::qcl_mode_t'(
                    w_data_r[`QCL_CFG_MODE_MSB:`QCL_CFG_MODE_LSB]);
                pol_r  <= w_data_r[`QCL_CFG_POL_BIT];
            end
        end

        // read views, reserved bits zero
        assign cfg_w[g]  = {29'h00000000, pol_r, mode_r};
        assign pos_w[g]  = {8'h00, cnt_r};
        assign cap_w[g]  = {8'h00, cap_r};
        assign stat_w[g] = {23'h000000, fast_s, idx_s, b_s, a_s,
                            dir_r, armed, err_r, done_r};
    end

endmodule // qcl_top

`default_nettype wire

// [testbench/qcl_top_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "qcl_regs.svh"

module qcl_top_monitor #(
    parameter int NCH = 5
) (
    // clock and reset
    input wire logic                   aclk,
    input wire logic                   aresetn,
    // write channels
    input wire logic [`QCL_ADDR_W-1:0] s_axi_awaddr,
    input wire logic                   s_axi_awvalid,
    input wire logic                   s_axi_awready,
    input wire logic                   s_axi_wvalid,
    input wire logic                   s_axi_wready,
    input wire logic [1:0]             s_axi_bresp,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready,
    // read channels
    input wire logic [`QCL_ADDR_W-1:0] s_axi_araddr,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic [31:0]            s_axi_rdata,
    input wire logic [1:0]             s_axi_rresp,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // handshake steps shared by the properties
    sequence s_wr_pair;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    chk_b_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_r_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_rd_answer: assert property (
        s_rd_take |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rd_refuse: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    chk_wr_refuse: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    chk_wr_answer: assert property (
        s_wr_pair |-> ##2 (s_axi_bvalid && !s_axi_awready))
        else $error("write answer late");
    chk_bad_rd: assert property (
        s_rd_take ##0 (s_axi_araddr[6:4] > 3'h4)
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("bad channel read not refused");
    chk_good_rd: assert property (
        s_rd_take ##0 (s_axi_araddr[6:4] < 3'h5) |=> s_axi_rresp == 2'h0)
        else $error("valid channel read refused");
    chk_bad_wr: assert property (
        s_wr_pair ##0 (s_axi_awaddr[6:4] > 3'h4)
        |-> ##2 s_axi_bresp == 2'h2)
        else $error("bad channel write not refused");
endmodule // qcl_top_monitor

bind qcl_top qcl_top_monitor #(.NCH(NCH)) mon_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// [testbench/qcl_enc_model.sv]
`timescale 1ns/1ps
`default_nettype none

module qcl_enc_model (
    // clock
    input wire logic  aclk,
    // encoder and fast lines toward the block
    output logic [4:0] enc_a,
    output logic [4:0] enc_b,
    output logic [4:0] enc_index,
    output logic [4:0] fast_in,
    // complementary lines, not taken in by the block
    output logic [4:0] enc_a_n,
    output logic [4:0] enc_b_n
);
    int ph [5] = '{0, 0, 0, 0, 0};

    // idle lines low from time zero
    initial begin
        enc_a = 5'h00;
        enc_b = 5'h00;
        enc_index = 5'h00;
        fast_in = 5'h00;
    end

    assign enc_a_n = ~enc_a;
    assign enc_b_n = ~enc_b;

    // gray step, d=1 forward, d=3 reverse, d=2 both lines at once
    task automatic move(input int ch, input int d);
        @(posedge aclk);
        ph[ch] = (ph[ch] + d) % 4;
        enc_a[ch] <= (ph[ch] == 1 || ph[ch] == 2);
        enc_b[ch] <= (ph[ch] >= 2);
        repeat (200) @(posedge aclk);
    endtask

    // index pulse, long enough to pass the filter
    task automatic pulse_idx(input int ch);
        @(posedge aclk);
        enc_index[ch] <= 1'b1;
        repeat (20) @(posedge aclk);
        enc_index[ch] <= 1'b0;
        repeat (20) @(posedge aclk);
    endtask

    // fast input level change
    task automatic set_fast(input int ch, input logic v);
        @(posedge aclk);
        fast_in[ch] <= v;
        repeat (20) @(posedge aclk);
    endtask
endmodule // qcl_enc_model
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [6:0]  awaddr = 7'h00, araddr = 7'h00;
    logic [31:0] wdata = 32'h0, rdata, seed = 32'h0001797b, d;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [4:0]  ea, eb, ei, fi;
    logic [3:0]  wstrb = 4'hf;
    logic [2:0]  prot = 3'h0;
    int          err_total = 0, checked = 0, cnt [5] = '{0, 0, 0, 0, 0}, cp;

    // 200 MHz clock
    initial forever #2.5 aclk = ~aclk;

    qcl_enc_model enc_u (.aclk(aclk), .enc_a(ea), .enc_b(eb),
        .enc_index(ei), .fast_in(fi), .enc_a_n(), .enc_b_n());

    qcl_top #(.NCH(5)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(prot), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(prot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .enc_a(ea), .enc_b(eb), .enc_index(ei),
        .fast_in(fi));

    // verdict and end of run
    task end_of_test;
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // one comparison
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // a stuck handshake ends the run
    task automatic tmo(input int n);
        if (n >= 1000) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
            end_of_test;
        end
    endtask

    function automatic logic [6:0] ad(input int ch, input int rg);
        return {ch[2:0], rg[1:0], 2'h0};
    endfunction

    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // bus write: address and data together, bready held until answered
    task automatic axw(input logic [6:0] a, input logic [31:0] v);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 1000; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        tmo(n);
    endtask

    // bus read
    task automatic axr(input logic [6:0] a);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 1000; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        tmo(n);
    endtask

    task automatic rdc(input logic [6:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        axr(a);
        cmp(d & m, e);
    endtask

    // step the encoder and the bench's own count
    task automatic mv(input int ch, input int dd);
        enc_u.move(ch, dd);
        if (dd == 1) cnt[ch]++;
        else if (dd == 3) cnt[ch]--;
    endtask

    task automatic rdp(input int ch);
        rdc(ad(ch, 1), 32'hffffffff, cnt[ch] & 32'h00ffffff);
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (int ch = 0; ch < 5; ch++) begin
            rdc(ad(ch, 0), 32'hffffffff, 32'h4);
            rdp(ch);
            rdc(ad(ch, 2), 32'hffffffff, 32'h0);
        end
        $display("test reset values done");
        repeat (4) mv(0, 1);
        rdp(0);
        repeat (6) mv(0, 3);
        rdp(0);
        $display("test direction and wrap done");
        axw(ad(1, 0), 32'h1);
        repeat (3) mv(1, 1);
        enc_u.pulse_idx(1);
        rdc(ad(1, 3), 32'h1, 32'h1);
        rdc(ad(1, 2), 32'hffffffff, cnt[1]);
        rdc(ad(1, 3), 32'h1, 32'h0);
        $display("test index capture done");
        for (int p = 0; p < 2; p++) begin
            axw(ad(2, 0), 32'h2 | (p << 2));
            mv(2, 1);
            enc_u.set_fast(2, 1'b1);
            if (p == 1) cp = cnt[2];
            mv(2, 1);
            enc_u.set_fast(2, 1'b0);
            if (p == 0) cp = cnt[2];
            mv(2, 1);
            rdc(ad(2, 2), 32'hffffffff, cp);
        end
        $display("test fast capture done");
        axw(ad(3, 0), 32'h7);
        mv(3, 1);
        enc_u.pulse_idx(3);
        mv(3, 1);
        rdc(ad(3, 3), 32'h5, 32'h0);
        enc_u.set_fast(3, 1'b1);
        rdc(ad(3, 3), 32'h4, 32'h4);
        mv(3, 1);
        enc_u.pulse_idx(3);
        cp = cnt[3];
        mv(3, 1);
        rdc(ad(3, 2), 32'hffffffff, cp);
        rdc(ad(3, 3), 32'h4, 32'h0);
        $display("test armed capture done");
        mv(4, 2);
        rdp(4);
        rdc(ad(4, 3), 32'h2, 32'h2);
        axw(ad(4, 3), 32'h2);
        rdc(ad(4, 3), 32'h2, 32'h0);
        for (int i = 0; i < 8; i++) begin
            mv(4, xs() & 32'h1 ? 1 : 3);
            prot <= 3'(xs());
            axw(ad(4, 1), xs());
            rdp(4);
        end
        // lane zero disabled: configuration must stay at reset value
        wstrb <= 4'he;
        axw(ad(4, 0), 32'h3);
        wstrb <= 4'hf;
        rdc(ad(4, 0), 32'hffffffff, 32'h4);
        axw(ad(4, 0), 32'h8);
        cnt[4] = 0;
        rdp(4);
        $display("test error and random walk done");
        axw(ad(5, 0), 32'hffffffff);
        cmp({30'h0, r}, 32'h2);
        axr(ad(7, 1));
        cmp({30'h0, r}, 32'h2);
        cmp(d, 32'h0);
        $display("test bad channel done");
        end_of_test;
    end
endmodule // testbench
`default_nettype wire
